// ### rtl/tpas_pkg.sv
// Package for the touch panel converter sequencer: channels, scans, modes, field layout.
// Assumes one 40 MHz core clock shared by all design files.
package tpas_pkg;
  // ****************************************
  // Channel, scan and mode codes
  // ****************************************
  typedef enum logic [2:0] {
    TPAS_CH_X = 3'h0, TPAS_CH_Y = 3'h1, TPAS_CH_Z1 = 3'h2, TPAS_CH_Z2 = 3'h3,
    TPAS_CH_BAT1 = 3'h4, TPAS_CH_BAT2 = 3'h5, TPAS_CH_TEMP = 3'h6, TPAS_CH_AUX = 3'h7
  } tpas_chan_t;

  // Scan selections
  localparam logic [2:0] SCAN_XY = 3'h0;
  localparam logic [2:0] SCAN_XYZ = 3'h1;
  localparam logic [2:0] SCAN_XYZ1 = 3'h2;
  localparam logic [2:0] SCAN_SINGLE = 3'h3;
  localparam logic [2:0] SCAN_DRIVE_ONLY = 3'h4;

  // Acquisition modes
  localparam logic [1:0] MODE_TOUCH = 2'h0;
  localparam logic [1:0] MODE_PEN_HOST = 2'h1;
  localparam logic [1:0] MODE_HOST = 2'h2;

  // Resolution codes and bit counts
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_10 = 4'hA;
  localparam logic [3:0] BITS_12 = 4'hC;

  // Sampling cycles of core clock before bit trials
  localparam logic [3:0] SAMPLE_CYCLES = 4'h4;
  localparam int RESULT_W = 12;
  localparam int NUM_CH = 8;

  // ****************************************
  // Converter control word
  // ****************************************
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] scan;
    tpas_chan_t chan;
    logic [1:0] avg_log2;
    logic [1:0] res;
    logic [3:0] clk_div;
    logic [7:0] settle;
  } tpas_ctrl_t;

  // Panel switch and mux state
  typedef struct packed {
    logic x_drv_on;
    logic y_drv_on;
    logic z_drv_on;
    tpas_chan_t mux_sel;
  } tpas_panel_t;
endpackage : tpas_pkg

// ### rtl/tpas_sar.sv
// Successive approximation engine: samples, then resolves 8, 10 or 12 bits.
// Assumes comp_i is already synchronous to core_clk_i.
`timescale 1ns/100ps
module tpas_sar (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic start_i,
  input wire logic [1:0] res_i,
  input wire logic conv_tick_i,
  // Analog comparator
  input wire logic comp_i,
  // Result
  output logic [tpas_pkg::RESULT_W-1:0] dac_o,
  output logic done_o,
  output logic busy_o
);
  logic [3:0] nbits;
  logic [3:0] bit_idx;
  logic [3:0] samp;

  // Lower resolutions run fewer trials, so they finish sooner
  always_comb begin
    unique case (res_i)
      tpas_pkg::RES_8: nbits = tpas_pkg::BITS_8;
      tpas_pkg::RES_10: nbits = tpas_pkg::BITS_10;
      default: nbits = tpas_pkg::BITS_12;
    endcase
  end

  // Trial sequencer; bits fill from the top of the chosen width, so results sit right aligned
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      dac_o <= '0;
      bit_idx <= 4'h0;
      samp <= 4'h0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        dac_o <= '0;
        samp <= tpas_pkg::SAMPLE_CYCLES;
        bit_idx <= nbits;
      end else if (busy_o && samp != 4'h0) begin
        samp <= samp - 4'h1;
      end else if (busy_o && conv_tick_i) begin
        if (bit_idx == 4'h0) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          // Comparator high keeps the bit under trial
          dac_o[bit_idx-4'h1] <= comp_i;
          bit_idx <= bit_idx - 4'h1;
        end
      end
    end
  end
endmodule : tpas_sar

// ### rtl/tpas_seq.sv
// Touch panel converter sequencer: plate drivers, settle delay, scans, result store.
// Assumes comparator and pen inputs come from the analog side, asynchronous.
`timescale 1ns/100ps
module tpas_seq (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Control word and host start strobe (core clock domain)
  input wire tpas_pkg::tpas_ctrl_t ctrl_i,
  input wire logic host_start_i,
  // Analog side (asynchronous)
  input wire logic comp_i,
  input wire logic pen_down_i,
  // Panel drive
  output tpas_pkg::tpas_panel_t panel_o,
  // Results
  output logic [tpas_pkg::NUM_CH*tpas_pkg::RESULT_W-1:0] result_o,
  output logic [tpas_pkg::NUM_CH-1:0] result_new_o,
  output logic busy_o,
  output logic pen_touch_data_ready_line_o
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] comp_sync;
  logic [1:0] pen_sync;
  logic pen_prev;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      comp_sync <= 2'h0;
      pen_sync <= 2'h0;
      pen_prev <= 1'b0;
    end else begin
      comp_sync <= {comp_sync[0], comp_i};
      pen_sync <= {pen_sync[0], pen_down_i};
      pen_prev <= pen_sync[1];
    end
  end
  wire pen_rise = pen_sync[1] && !pen_prev;

  // ****************************************
  // Converter clock divider
  // ****************************************
  logic [3:0] div_cnt;
  logic conv_tick;
  // Divide the core clock by clk_div+1
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt <= 4'h0;
      conv_tick <= 1'b0;
    end else if (div_cnt >= ctrl_i.clk_div) begin
      div_cnt <= 4'h0;
      conv_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 4'h1;
      conv_tick <= 1'b0;
    end
  end

  // ****************************************
  // Scan sequencer
  // ****************************************
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_SETTLE = 5'h02, S_CONV = 5'h04, S_WAIT = 5'h08, S_STORE = 5'h10
  } tpas_state_t;
  tpas_state_t state;
  tpas_pkg::tpas_chan_t chan;
  logic [7:0] settle_cnt;
  logic [3:0] avg_left;
  logic [15:0] acc;
  logic sar_start;
  logic sar_done;
  logic sar_busy;
  logic [tpas_pkg::RESULT_W-1:0] sar_val;

  // Next channel of a scan; Y precedes X, then pressure reads follow
  function automatic tpas_pkg::tpas_chan_t next_chan(input logic [2:0] scan,
                                                      input tpas_pkg::tpas_chan_t c);
    next_chan = tpas_pkg::TPAS_CH_Y;
    unique case (c)
      tpas_pkg::TPAS_CH_Y: next_chan = tpas_pkg::TPAS_CH_X;
      tpas_pkg::TPAS_CH_X: next_chan = tpas_pkg::TPAS_CH_Z1;
      tpas_pkg::TPAS_CH_Z1: next_chan = (scan == tpas_pkg::SCAN_XYZ) ? tpas_pkg::TPAS_CH_Z2
                                                                      : tpas_pkg::TPAS_CH_Y;
      default: next_chan = tpas_pkg::TPAS_CH_Y;
    endcase
  endfunction : next_chan

  // True when c is the final channel of the scan
  function automatic logic last_chan(input logic [2:0] scan, input tpas_pkg::tpas_chan_t c);
    unique case (scan)
      tpas_pkg::SCAN_XY: last_chan = (c == tpas_pkg::TPAS_CH_X);
      tpas_pkg::SCAN_XYZ: last_chan = (c == tpas_pkg::TPAS_CH_Z2);
      tpas_pkg::SCAN_XYZ1: last_chan = (c == tpas_pkg::TPAS_CH_Z1);
      default: last_chan = 1'b1;
    endcase
  endfunction : last_chan

  wire auto_mode = (ctrl_i.mode != tpas_pkg::MODE_HOST);
  wire single = (ctrl_i.scan == tpas_pkg::SCAN_SINGLE);
  wire drive_only = (ctrl_i.scan == tpas_pkg::SCAN_DRIVE_ONLY);
  // Start source chosen by mode
  wire trig = (ctrl_i.mode == tpas_pkg::MODE_TOUCH) ? pen_rise
            : (ctrl_i.mode == tpas_pkg::MODE_PEN_HOST) ? (host_start_i && pen_sync[1])
            : host_start_i;

  // Main state machine
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= S_IDLE;
      chan <= tpas_pkg::TPAS_CH_Y;
      settle_cnt <= 8'h00;
      avg_left <= 4'h0;
      acc <= 16'h0000;
      sar_start <= 1'b0;
    end else begin
      sar_start <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (trig && !drive_only) begin
            chan <= single ? ctrl_i.chan : tpas_pkg::TPAS_CH_Y;
            settle_cnt <= ctrl_i.settle;
            // Host mode skips the delay; host waited after driving the plates
            state <= auto_mode ? S_SETTLE : S_CONV;
          end
        end
        S_SETTLE: begin
          if (settle_cnt == 8'h00) begin
            state <= S_CONV;
          end else begin
            settle_cnt <= settle_cnt - 8'h01;
          end
        end
        S_CONV: begin
          acc <= 16'h0000;
          avg_left <= 4'h1 << ctrl_i.avg_log2;
          sar_start <= 1'b1;
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (sar_done) begin
            acc <= acc + {4'h0, sar_val};
            avg_left <= avg_left - 4'h1;
            if (avg_left == 4'h1) begin
              state <= S_STORE;
            end else begin
              sar_start <= 1'b1;
            end
          end
        end
        S_STORE: begin
          if (last_chan(ctrl_i.scan, chan)) begin
            state <= S_IDLE;
          end else begin
            chan <= next_chan(ctrl_i.scan, chan);
            settle_cnt <= ctrl_i.settle;
            state <= auto_mode ? S_SETTLE : S_CONV;
          end
        end
      endcase
    end
  end

  tpas_sar u_sar (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(sar_start),
    .res_i(ctrl_i.res),
    .conv_tick_i(conv_tick),
    .comp_i(comp_sync[1]),
    .dac_o(sar_val),
    .done_o(sar_done),
    .busy_o(sar_busy)
  );

  // ****************************************
  // Results and panel drive
  // ****************************************
  // Averaged unsigned result into the channel's slot; new flag pulses one cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_o <= '0;
      result_new_o <= '0;
    end else begin
      result_new_o <= '0;
      if (state == S_STORE) begin
        result_o[chan*tpas_pkg::RESULT_W +: tpas_pkg::RESULT_W] <=
          tpas_pkg::RESULT_W'(acc >> ctrl_i.avg_log2);
        result_new_o[chan] <= 1'b1;
      end
    end
  end

  // Plates: Y read drives Y plate and senses X-plus; X read the opposite
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      panel_o <= '{x_drv_on: 1'b0, y_drv_on: 1'b0, z_drv_on: 1'b0,
                   mux_sel: tpas_pkg::TPAS_CH_Y};
      busy_o <= 1'b0;
      pen_touch_data_ready_line_o <= 1'b1;
    end else begin
      busy_o <= (state != S_IDLE);
      pen_touch_data_ready_line_o <= !pen_sync[1] && (state == S_IDLE);
      if (state == S_IDLE && drive_only) begin
        panel_o.y_drv_on <= (ctrl_i.chan == tpas_pkg::TPAS_CH_Y);
        panel_o.x_drv_on <= (ctrl_i.chan == tpas_pkg::TPAS_CH_X);
        panel_o.z_drv_on <= (ctrl_i.chan == tpas_pkg::TPAS_CH_Z1) ||
                            (ctrl_i.chan == tpas_pkg::TPAS_CH_Z2);
        panel_o.mux_sel <= ctrl_i.chan;
      end else if (state != S_IDLE) begin
        panel_o.mux_sel <= chan;
        panel_o.y_drv_on <= (chan == tpas_pkg::TPAS_CH_Y);
        panel_o.x_drv_on <= (chan == tpas_pkg::TPAS_CH_X);
        panel_o.z_drv_on <= (chan == tpas_pkg::TPAS_CH_Z1) || (chan == tpas_pkg::TPAS_CH_Z2);
      end else begin
        panel_o.x_drv_on <= 1'b0;
        panel_o.y_drv_on <= 1'b0;
        panel_o.z_drv_on <= 1'b0;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  settle_wait_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state == S_SETTLE && settle_cnt != 8'h00) |=> state == S_SETTLE)
    else $error("settle delay cut short");
  y_before_x_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state == S_STORE && chan == tpas_pkg::TPAS_CH_Y && !single) |=> chan == tpas_pkg::TPAS_CH_X)
    else $error("X did not follow Y");
  y_drive_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state == S_WAIT && chan == tpas_pkg::TPAS_CH_Y) |-> panel_o.y_drv_on && !panel_o.x_drv_on)
    else $error("Y plate not driven during Y read");
  store_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state == S_STORE) |=> result_new_o[$past(chan)])
    else $error("result flag missing");
  drive_only_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state == S_IDLE && drive_only) |=> state == S_IDLE && !sar_busy)
    else $error("drive only command converted");
  host_nowait_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state == S_IDLE && trig && !drive_only && !auto_mode) |=> state == S_CONV)
    else $error("host mode did not start at once");
  z2_end_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state == S_STORE && ctrl_i.scan == tpas_pkg::SCAN_XYZ && chan == tpas_pkg::TPAS_CH_Z1)
    |=> chan == tpas_pkg::TPAS_CH_Z2)
    else $error("Z2 skipped");
  z1_end_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state == S_STORE && ctrl_i.scan == tpas_pkg::SCAN_XYZ1 && chan == tpas_pkg::TPAS_CH_Z1)
    |=> state == S_IDLE)
    else $error("scan did not end after Z1");
  div_tick_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (conv_tick && ctrl_i.clk_div == $past(ctrl_i.clk_div) && ctrl_i.clk_div != 4'h0)
    |=> !conv_tick)
    else $error("converter clock not divided");
endmodule : tpas_seq

// ### tb/tpas_panel_model.sv
// Panel and comparator model standing on the analog side of the sequencer.
// Assumes mux_sel stays stable through each sample; comparator is read async.
`timescale 1ns/100ps
module tpas_panel_model (
  // Clock
  input wire logic core_clk_i,
  // Panel drive from the sequencer
  input wire tpas_pkg::tpas_panel_t panel_i,
  // Comparator to the sequencer
  output logic comp_o
);
  logic flip = 1'b0;
  logic driven;

  // A panel lead (X, Y, Z1, Z2) with no plate driven floats, so the comparator wanders each cycle
  always @(posedge core_clk_i) begin
    flip <= ~flip;
  end

  // Even channels read full scale and odd ones zero, only while a source feeds the mux
  assign driven = panel_i.x_drv_on | panel_i.y_drv_on | panel_i.z_drv_on | panel_i.mux_sel[2];
  assign comp_o = driven ? ~panel_i.mux_sel[0] : flip;
endmodule : tpas_panel_model

// ### tb/tb_touch_panel_adc_sequencer.sv
// Self-checking bench for the touch panel converter sequencer.
// Assumes the panel model answers the comparator from the mux selection.
`timescale 1ns/100ps
module tb_touch_panel_adc_sequencer;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  tpas_pkg::tpas_ctrl_t ctrl = '0;
  logic host_start = 1'b0;
  logic pen = 1'b0;
  logic comp;
  tpas_pkg::tpas_panel_t panel;
  logic [tpas_pkg::NUM_CH*tpas_pkg::RESULT_W-1:0] result;
  logic [tpas_pkg::NUM_CH-1:0] result_new;
  logic busy;
  logic ready_b;
  logic [7:0] mask;
  int order[$];
  int first;
  int n_errors = 0;
  int checked = 0;

  tpas_seq uut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ctrl_i(ctrl),
    .host_start_i(host_start), .comp_i(comp), .pen_down_i(pen), .panel_o(panel),
    .result_o(result), .result_new_o(result_new), .busy_o(busy),
    .pen_touch_data_ready_line_o(ready_b));
  tpas_panel_model model (.core_clk_i(core_clk_i), .panel_i(panel), .comp_o(comp));

  // ****************************************
  // Clock, checks and scan driver
  // ****************************************
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Full scale right-aligned at the chosen width, zero on odd channels
  function automatic logic [11:0] exp_val(input int ch, input logic [1:0] res);
    if (ch % 2 == 1) return 12'h000;
    return (res == tpas_pkg::RES_8) ? 12'h0FF : (res == tpas_pkg::RES_10) ? 12'h3FF : 12'hFFF;
  endfunction : exp_val

  task automatic setc(input logic [1:0] m, input logic [2:0] s, input int ch,
                      input logic [1:0] r, input logic [7:0] st);
    @(posedge core_clk_i);
    ctrl.mode <= m;
    ctrl.scan <= s;
    ctrl.chan <= tpas_pkg::tpas_chan_t'(ch);
    ctrl.avg_log2 <= 2'h1;
    ctrl.res <= r;
    ctrl.clk_div <= 4'h1;
    ctrl.settle <= st;
    repeat (3) @(posedge core_clk_i);
  endtask : setc

  // Triggers by pen rise or host strobe, collects stored channels in order
  task automatic run(input logic by_pen, output int cyc);
    int i;
    mask = '0;
    order.delete();
    first = -1;
    @(posedge core_clk_i);
    if (by_pen) pen <= 1'b1;
    else host_start <= 1'b1;
    @(posedge core_clk_i);
    host_start <= 1'b0;
    for (i = 0; i < 8000; i++) begin
      @(posedge core_clk_i);
      #1;
      for (int k = 0; k < 8; k++) begin
        if (result_new[k] === 1'b1) begin
          order.push_back(k);
          if (first < 0) first = i;
        end
      end
      mask |= result_new;
      if (i > 4 && busy === 1'b0) break;
    end
    // A scan that never ends counts as a mismatch here
    chk({11'h000, busy}, 12'h000);
    cyc = i;
  endtask : run

  task automatic chk_res(input int ch, input logic [1:0] res);
    chk(result[ch*12 +: 12], exp_val(ch, res));
  endtask : chk_res

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_xy_host();
    int c;
    setc(tpas_pkg::MODE_HOST, tpas_pkg::SCAN_XY, 0, tpas_pkg::RES_12, 8'hC8);
    chk({11'h000, ready_b}, 12'h001);
    run(1'b0, c);
    chk({4'h0, mask}, 12'h003);
    chk(12'(order[0]), 12'h001);
    chk(12'(order[order.size()-1]), 12'h000);
    chk_res(1, tpas_pkg::RES_12);
    chk_res(0, tpas_pkg::RES_12);
    chk(first < 200, 1'b1);
  endtask : t_xy_host

  task automatic t_xyz_touch();
    int c;
    setc(tpas_pkg::MODE_TOUCH, tpas_pkg::SCAN_XYZ, 0, tpas_pkg::RES_8, 8'hC8);
    run(1'b1, c);
    chk({4'h0, mask & 8'h0D}, 12'h00D);
    chk(first > 200, 1'b1);
    chk_res(0, tpas_pkg::RES_8);
    chk_res(2, tpas_pkg::RES_8);
    chk_res(3, tpas_pkg::RES_8);
    @(posedge core_clk_i);
    pen <= 1'b0;
  endtask : t_xyz_touch

  task automatic t_xyz1_pen_host();
    int c8;
    int c12;
    setc(tpas_pkg::MODE_PEN_HOST, tpas_pkg::SCAN_XYZ1, 0, tpas_pkg::RES_12, 8'h10);
    run(1'b0, c12);
    chk({4'h0, mask}, 12'h000);
    @(posedge core_clk_i);
    pen <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1;
    chk({11'h000, ready_b}, 12'h000);
    run(1'b0, c12);
    chk({4'h0, mask}, 12'h007);
    @(posedge core_clk_i);
    ctrl.res <= tpas_pkg::RES_8;
    repeat (3) @(posedge core_clk_i);
    run(1'b0, c8);
    chk(c8 < c12, 1'b1);
    chk_res(2, tpas_pkg::RES_8);
    chk_res(1, tpas_pkg::RES_8);
    @(posedge core_clk_i);
    pen <= 1'b0;
  endtask : t_xyz1_pen_host

  task automatic t_single();
    int c;
    for (int ch = 4; ch < 8; ch++) begin
      setc(tpas_pkg::MODE_HOST, tpas_pkg::SCAN_SINGLE, ch, tpas_pkg::RES_10, 8'h00);
      // Sweep averaging depth and converter divider across the four channels
      ctrl.avg_log2 <= 2'(ch - 4);
      ctrl.clk_div <= 4'(ch - 4);
      run(1'b0, c);
      chk({4'h0, mask}, 12'h001 << ch);
      chk_res(ch, tpas_pkg::RES_10);
    end
  endtask : t_single

  task automatic t_drive_only();
    int c;
    setc(tpas_pkg::MODE_HOST, tpas_pkg::SCAN_DRIVE_ONLY, 0, tpas_pkg::RES_12, 8'h00);
    run(1'b0, c);
    repeat (40) @(posedge core_clk_i);
    #1;
    chk({4'h0, mask}, 12'h000);
    chk(panel.x_drv_on, 1'b1);
    setc(tpas_pkg::MODE_HOST, tpas_pkg::SCAN_SINGLE, 0, tpas_pkg::RES_12, 8'h00);
    run(1'b0, c);
    chk({4'h0, mask}, 12'h001);
  endtask : t_drive_only

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    t_xy_host();
    t_xyz_touch();
    t_xyz1_pen_host();
    t_single();
    t_drive_only();
    finish_test();
  end

  // Watchdog well beyond the few thousand cycles the scans need
  initial begin
    #(25 * 60000);
    n_errors++;
    finish_test();
  end
endmodule : tb_touch_panel_adc_sequencer
